// file: verilog/css_clock_source_startup_sequencer.sv
// Clock source selection, divide by eight and reset start-up sequencing with an APB register slave.
// Assumes all inputs except nrst, including watchdog and oscillator tick pulses, are synchronous to clk.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Function
// RULE1 - Four-bit source select picks clock source
// RULE2 - Code 0001 is reserved, no source
// RULE3 - Fuse one is unprogrammed, zero programmed
// RULE4 - Default fuses: RC, startup 10, divide on
// RULE5 - Programmed divide fuse divides clock by eight
// RULE6 - Hold reset for watchdog-timed time-out
// RULE7 - Time-out is 0, 512 or 8192 cycles
// RULE8 - Oscillator cycle count holds reset before release
// RULE9 - Start-up count depends on clock type
// RULE10 - Reset start uses time-out plus start-up
// RULE11 - Wake from sleep uses start-up count only
// RULE12 - Low-power crystal range from bits three..one
// RULE13 - Low-power crystal, low bit zero, count table
// RULE14 - Low-power crystal, low bit one, count table
// RULE15 - Converter clock runs while CPU halted
// RULE16 - New external reset restarts both counters
// RULE17 - Time-out finishes before start-up count begins
module css_clock_source_startup_sequencer
   import css_pkg::*;
#(
   parameter int TIMEOUT_LONG_CYCLES = CSS_TIMEOUT_LONG,
   parameter int START_16K_CYCLES = CSS_START_16K,
   parameter int START_32K_CYCLES = CSS_START_32K
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Fuse levels and other reset sources.
   input wire logic [3:0] clockSourceSelect,
   input wire logic [1:0] startupTimeSelect,
   input wire logic divideByEightFuse,
   input wire logic otherResetActive,
   // Timing ticks and wake-up event.
   input wire logic watchdogTick,
   input wire logic [CSS_NUM_SOURCES-1:0] oscillatorTick,
   input wire logic wakeUp,
   // Clock, reset and oscillator range outputs.
   output logic coreReset,
   output logic systemClockEnable,
   output logic cpuClockEnable,
   output logic ioClockEnable,
   output logic converterClockEnable,
   output logic [2:0] oscillatorRangeSelect,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // Map the source select code onto a source index.
   function automatic int sourceIndex(input logic [3:0] src);
      if (src[3]) begin
         return CSS_SRC_LP_XTAL; // RULE1
      end else if (src[2:1] == 2'h3) begin
         return CSS_SRC_FS_XTAL;
      end else if (src[2:1] == 2'h2) begin
         return CSS_SRC_LF_XTAL;
      end else if (src == 4'h3) begin
         return CSS_SRC_RC_128K;
      end else if (src == 4'h2) begin
         return CSS_SRC_RC_CAL;
      end else if (src == 4'h0) begin
         return CSS_SRC_EXTERNAL;
      end
      return CSS_SRC_NONE; // RULE2
   endfunction

   // Watchdog cycles of reset time-out for a fuse setting.
   function automatic logic [13:0] timeoutCycles(input logic [3:0] src, input logic [1:0] sut);
      int idx;
      int cyc;
      idx = sourceIndex(src);
      cyc = 0;
      if (idx == CSS_SRC_LP_XTAL || idx == CSS_SRC_FS_XTAL) begin
         // RULE13 RULE14
         unique case ({src[0], sut})
            3'h0, 3'h3, 3'h6: cyc = CSS_TIMEOUT_SHORT;
            3'h1, 3'h4, 3'h7: cyc = TIMEOUT_LONG_CYCLES;
            default: cyc = 0;
         endcase
      end else if (idx != CSS_SRC_NONE) begin
         unique case (sut)
            2'h1: cyc = CSS_TIMEOUT_SHORT; // RULE7
            2'h2: cyc = TIMEOUT_LONG_CYCLES;
            default: cyc = 0;
         endcase
      end
      return cyc[13:0];
   endfunction

   // Oscillator start-up cycles for a fuse setting.
   function automatic logic [16:0] startupCycles(input logic [3:0] src, input logic [1:0] sut);
      int idx;
      int cyc;
      idx = sourceIndex(src);
      cyc = CSS_START_EXT; // RULE9
      if (idx == CSS_SRC_LP_XTAL || idx == CSS_SRC_FS_XTAL) begin
         if (!src[0]) begin
            cyc = sut[1] ? CSS_START_1K : CSS_START_258; // RULE13
         end else begin
            cyc = (sut == 2'h0) ? CSS_START_1K : START_16K_CYCLES; // RULE14
         end
      end else if (idx == CSS_SRC_LF_XTAL) begin
         cyc = src[0] ? START_32K_CYCLES : CSS_START_1K;
      end
      return cyc[16:0];
   endfunction

   // Reset synchroniser: asynchronous assertion, release after two edges.
   logic rstMeta; // First stage, read only by the second.
   logic rstN; // Released reset used by the rest of the block.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN <= rstMeta;
      end
   end

   // Sequencer state and counters.
   css_state_type state, next_state;
   logic [13:0] timeoutCount, next_timeoutCount; // Watchdog cycles counted.
   logic [16:0] oscCount, next_oscCount; // Synchronous count of source cycles.
   logic [3:0] srcLatch, next_srcLatch; // Fuses captured while in hold.
   logic [1:0] sutLatch, next_sutLatch;
   logic divLatch, next_divLatch;
   logic fromReset, next_fromReset; // Start-up includes the reset extras.
   logic [2:0] divCount, next_divCount; // Divide-by-eight phase.
   logic [1:0] sleepMode, next_sleepMode; // Software sleep request.
   logic next_coreReset;
   logic next_systemClockEnable;
   logic next_cpuClockEnable;
   logic next_ioClockEnable;
   logic next_converterClockEnable;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   // Decoded values of the captured fuses.
   int srcIdx;
   logic srcTick; // One tick of the selected source.
   logic srcReserved;
   logic [13:0] timeoutTarget;
   logic [16:0] oscTarget;
   logic apbAccess; // Completing access phase.
   logic apbWrite;

   always_comb begin
      srcIdx = sourceIndex(srcLatch);
      srcTick = oscillatorTick[srcIdx]; // RULE1
      // Low-frequency crystal with start-up select 11 is reserved too, so it never clocks.
      srcReserved = (srcIdx == CSS_SRC_NONE) || (srcIdx == CSS_SRC_LF_XTAL && sutLatch == 2'h3); // RULE2
      timeoutTarget = timeoutCycles(srcLatch, sutLatch);
      oscTarget = startupCycles(srcLatch, sutLatch) + (fromReset ? 17'(CSS_START_EXTRA_RESET) : 17'h00000);
      apbAccess = psel && penable && pready;
      apbWrite = apbAccess && pwrite && (paddr == CSS_ADDR_CONTROL);
   end

   // Next-state logic of the start-up sequence, fuse capture and sleep mode.
   always_comb begin
      next_state = state;
      next_timeoutCount = timeoutCount;
      next_oscCount = oscCount;
      next_srcLatch = srcLatch;
      next_sutLatch = sutLatch;
      next_divLatch = divLatch;
      next_fromReset = fromReset;
      next_sleepMode = sleepMode;
      unique case (state)
         CSS_HOLD: begin
            // Fuses are sampled here so that a changed fuse takes effect on the next start.
            next_srcLatch = clockSourceSelect;
            next_sutLatch = startupTimeSelect;
            next_divLatch = divideByEightFuse;
            next_timeoutCount = 14'h0000;
            next_oscCount = 17'h00000;
            next_fromReset = 1'b1; // RULE10
            if (!otherResetActive) begin
               next_state = (timeoutCycles(clockSourceSelect, startupTimeSelect) == 14'h0000) ? CSS_OSCSTART
                  : CSS_TIMEOUT; // RULE6 RULE7
            end
         end
         CSS_TIMEOUT: begin
            if (watchdogTick) begin
               next_timeoutCount = timeoutCount + 14'h0001; // RULE6
               if (timeoutCount + 14'h0001 >= timeoutTarget) begin
                  next_state = CSS_OSCSTART; // RULE17
               end
            end
         end
         CSS_OSCSTART: begin
            if (srcTick && !srcReserved) begin
               next_oscCount = oscCount + 17'h00001; // RULE8
               if (oscCount + 17'h00001 >= oscTarget) begin
                  next_state = CSS_RUN;
               end
            end
         end
         CSS_RUN: begin
            if (sleepMode != CSS_MODE_NONE) begin
               next_state = CSS_SLEEP;
            end
         end
         CSS_SLEEP: begin
            if (wakeUp) begin
               next_sleepMode = CSS_MODE_NONE;
               next_oscCount = 17'h00000;
               next_fromReset = 1'b0; // RULE11
               // Noise reduction keeps the oscillator running, so no start-up wait is needed.
               next_state = (sleepMode == CSS_MODE_NOISE) ? CSS_RUN : CSS_OSCSTART; // RULE11
            end
         end
      endcase
      // A software write beats the hardware clear on wake in the same cycle.
      if (apbWrite) begin
         next_sleepMode = pwdata[CSS_CTRL_MODE_LSB +: 2];
      end
      if (otherResetActive) begin
         next_state = CSS_HOLD; // RULE16
         next_timeoutCount = 14'h0000;
         next_oscCount = 17'h00000;
      end
   end

   // Output clock enables and divider.
   always_comb begin
      next_divCount = divCount;
      next_systemClockEnable = 1'b0;
      if (srcTick && !srcReserved) begin
         next_divCount = divCount + 3'h1;
         // RULE3 RULE5
         next_systemClockEnable = divLatch || (divCount == CSS_DIV_LAST);
      end
      next_coreReset = !(next_state == CSS_RUN || next_state == CSS_SLEEP); // RULE8
      next_cpuClockEnable = (next_state == CSS_RUN);
      next_ioClockEnable = (next_state == CSS_RUN);
      // RULE15
      next_converterClockEnable = (next_state == CSS_RUN)
         || (next_state == CSS_SLEEP && sleepMode == CSS_MODE_NOISE);
   end

   // APB slave: one wait state, then the answer with pready.
   always_comb begin
      next_pready = psel && penable && !pready;
      next_prdata = 32'h00000000;
      next_pslverr = 1'b0;
      if (next_pready) begin
         unique case (paddr)
            CSS_ADDR_CONTROL: next_prdata[CSS_CTRL_MODE_LSB +: 2] = sleepMode;
            CSS_ADDR_STATUS: begin
               next_prdata[CSS_STAT_STATE_LSB +: 3] = state;
               next_prdata[CSS_STAT_RESERVED_BIT] = srcReserved;
               next_prdata[CSS_STAT_SOURCE_LSB +: 4] = srcLatch;
               next_prdata[CSS_STAT_RESET_BIT] = coreReset;
            end
            CSS_ADDR_FUSES: begin
               next_prdata[CSS_FUSE_SOURCE_LSB +: 4] = srcLatch;
               next_prdata[CSS_FUSE_STARTUP_LSB +: 2] = sutLatch;
               next_prdata[CSS_FUSE_DIV_BIT] = divLatch;
            end
            default: next_pslverr = 1'b1;
         endcase
         if (pwrite && paddr != CSS_ADDR_CONTROL) begin
            next_prdata = 32'h00000000;
            next_pslverr = 1'b1; // Status and fuse words cannot be written.
         end
      end
   end

   // All state registers but the reset synchroniser; fuse copies reset to the shipped values.
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state <= CSS_HOLD;
         timeoutCount <= 14'h0000;
         oscCount <= 17'h00000;
         srcLatch <= CSS_DEFAULT_SOURCE; // RULE4
         sutLatch <= CSS_DEFAULT_STARTUP;
         divLatch <= CSS_DEFAULT_DIV;
         fromReset <= 1'b1;
         divCount <= 3'h0;
         sleepMode <= CSS_MODE_NONE;
         coreReset <= 1'b1;
         systemClockEnable <= 1'b0;
         cpuClockEnable <= 1'b0;
         ioClockEnable <= 1'b0;
         converterClockEnable <= 1'b0;
         oscillatorRangeSelect <= 3'h0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         state <= next_state;
         timeoutCount <= next_timeoutCount;
         oscCount <= next_oscCount;
         srcLatch <= next_srcLatch;
         sutLatch <= next_sutLatch;
         divLatch <= next_divLatch;
         fromReset <= next_fromReset;
         divCount <= next_divCount;
         sleepMode <= next_sleepMode;
         coreReset <= next_coreReset;
         systemClockEnable <= next_systemClockEnable;
         cpuClockEnable <= next_cpuClockEnable;
         ioClockEnable <= next_ioClockEnable;
         converterClockEnable <= next_converterClockEnable;
         oscillatorRangeSelect <= next_srcLatch[3] ? next_srcLatch[3:1] : 3'h0; // RULE12
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Checks of the sequence.
   sequence s_holdRelease;
      state == CSS_HOLD && !otherResetActive;
   endsequence
   sequence s_wakeFromDeepSleep;
      state == CSS_SLEEP && wakeUp && sleepMode == CSS_MODE_POWERDOWN && !otherResetActive && !apbWrite;
   endsequence
   property p_reservedHangs;
      @(posedge clk) disable iff (!rstN)
         state == CSS_OSCSTART && srcReserved && !otherResetActive |=> state == CSS_OSCSTART;
   endproperty
   a_reservedHangs: assert property (p_reservedHangs) else $error("Reserved source left start-up"); // RULE2
   property p_defaultFuses;
      @(posedge clk) $rose(rstN) |-> srcLatch == CSS_DEFAULT_SOURCE && sutLatch == CSS_DEFAULT_STARTUP && !divLatch;
   endproperty
   a_defaultFuses: assert property (p_defaultFuses) else $error("Fuse copies not at shipped values"); // RULE4
   property p_divideEight;
      @(posedge clk) disable iff (!rstN)
         srcTick && !srcReserved && !divLatch && divCount != CSS_DIV_LAST |=> !systemClockEnable;
   endproperty
   a_divideEight: assert property (p_divideEight) else $error("System clock not divided by eight"); // RULE5
   property p_noDivide;
      @(posedge clk) disable iff (!rstN) srcTick && !srcReserved && divLatch |=> systemClockEnable;
   endproperty
   a_noDivide: assert property (p_noDivide) else $error("Undivided clock tick lost"); // RULE3
   property p_restart;
      @(posedge clk) disable iff (!rstN) otherResetActive |=> state == CSS_HOLD ##1 coreReset && oscCount == 17'h00000;
   endproperty
   a_restart: assert property (p_restart) else $error("External reset did not restart sequence"); // RULE16
   property p_skipTimeout;
      // With no other reset pending, a zero time-out must go straight to the start-up count.
      @(posedge clk) disable iff (!rstN)
         s_holdRelease ##0 timeoutCycles(clockSourceSelect, startupTimeSelect) == 14'h0000 |=> state == CSS_OSCSTART;
   endproperty
   a_skipTimeout: assert property (p_skipTimeout) else $error("Zero time-out not skipped"); // RULE7
   property p_wakeNoTimeout;
      @(posedge clk) disable iff (!rstN)
         s_wakeFromDeepSleep |=> state == CSS_OSCSTART && !fromReset ##1 state != CSS_TIMEOUT;
   endproperty
   a_wakeNoTimeout: assert property (p_wakeNoTimeout) else $error("Wake-up used time-out"); // RULE11
   property p_timeoutFirst;
      @(posedge clk) disable iff (!rstN) state == CSS_TIMEOUT |-> oscCount == 17'h00000;
   endproperty
   a_timeoutFirst: assert property (p_timeoutFirst) else $error("Start-up count ran during time-out"); // RULE17
   property p_releaseAfterCount;
      @(posedge clk) disable iff (!rstN) state == CSS_OSCSTART ##1 state == CSS_RUN
         |-> $past(oscCount) + 17'h00001 >= $past(oscTarget) ##1 !coreReset;
   endproperty
   a_releaseAfterCount: assert property (p_releaseAfterCount) else $error("Reset released early"); // RULE8
   property p_converterRuns;
      @(posedge clk) disable iff (!rstN)
         state == CSS_SLEEP && sleepMode == CSS_MODE_NOISE && !wakeUp && !otherResetActive
         |=> converterClockEnable && !cpuClockEnable && !ioClockEnable;
   endproperty
   a_converterRuns: assert property (p_converterRuns) else $error("Converter clock halted in noise mode"); // RULE15
endmodule

// file: verilog/css_pkg.sv
// Constants, fuse encodings and state type for the clock source start-up sequencer.
// Assumes fuse values arrive as static levels and the APB master follows the usual two-phase protocol.
package css_pkg;
   // Register byte addresses on the APB bus.
   localparam logic [7:0] CSS_ADDR_CONTROL = 8'h00;
   localparam logic [7:0] CSS_ADDR_STATUS = 8'h04;
   localparam logic [7:0] CSS_ADDR_FUSES = 8'h08;
   // Control register fields: sleep mode request in bits 1..0.
   localparam int CSS_CTRL_MODE_LSB = 0;
   localparam logic [1:0] CSS_MODE_NONE = 2'h0;
   localparam logic [1:0] CSS_MODE_NOISE = 2'h1;
   localparam logic [1:0] CSS_MODE_POWERDOWN = 2'h2;
   // Status register field positions.
   localparam int CSS_STAT_STATE_LSB = 0;
   localparam int CSS_STAT_RESERVED_BIT = 3;
   localparam int CSS_STAT_SOURCE_LSB = 4;
   localparam int CSS_STAT_RESET_BIT = 8;
   // Fuse register field positions.
   localparam int CSS_FUSE_SOURCE_LSB = 0;
   localparam int CSS_FUSE_STARTUP_LSB = 4;
   localparam int CSS_FUSE_DIV_BIT = 6;
   // Shipped fuse values; a zero bit is programmed, a one bit unprogrammed.
   localparam logic [3:0] CSS_DEFAULT_SOURCE = 4'h2;
   localparam logic [1:0] CSS_DEFAULT_STARTUP = 2'h2;
   localparam logic CSS_DEFAULT_DIV = 1'b0;
   // Clock source indices into the oscillator tick vector.
   localparam int CSS_SRC_NONE = 0;
   localparam int CSS_SRC_EXTERNAL = 1;
   localparam int CSS_SRC_RC_CAL = 2;
   localparam int CSS_SRC_RC_128K = 3;
   localparam int CSS_SRC_LF_XTAL = 4;
   localparam int CSS_SRC_FS_XTAL = 5;
   localparam int CSS_SRC_LP_XTAL = 6;
   localparam int CSS_NUM_SOURCES = 7;
   // Watchdog oscillator cycle counts for the reset time-out.
   localparam int CSS_TIMEOUT_SHORT = 512;
   localparam int CSS_TIMEOUT_LONG = 8192;
   // Oscillator start-up counts in cycles of the selected source.
   localparam int CSS_START_EXT = 6;
   localparam int CSS_START_258 = 258;
   localparam int CSS_START_1K = 1024;
   localparam int CSS_START_16K = 16384;
   localparam int CSS_START_32K = 32768;
   localparam int CSS_START_EXTRA_RESET = 14;
   // Divider terminal count for divide by eight.
   localparam logic [2:0] CSS_DIV_LAST = 3'h7;
   // Sequencer states.
   typedef enum logic [2:0] {CSS_HOLD, CSS_TIMEOUT, CSS_OSCSTART, CSS_RUN, CSS_SLEEP} css_state_type;
endpackage

// file: bench/css_osc_model.sv
// Partner model of the clock sources: watchdog oscillator and every selectable source.
// Assumes one clk domain; each tick is a one-cycle pulse, and phases restart while phaseReset is high.
`timescale 1ns/1ps
module css_osc_model
   import css_pkg::*;
#(
   parameter int WD_PERIOD = 2,
   parameter int OSC_PERIOD = 7
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Phase restart and slow-oscillator request.
   input wire logic phaseReset,
   input wire logic stall,
   // Tick outputs.
   output logic watchdogTick,
   output logic [CSS_NUM_SOURCES-1:0] oscillatorTick
);
   // Index 0 means no source, so it never ticks.
   localparam logic [CSS_NUM_SOURCES-1:0] ALL_TICKS = {{(CSS_NUM_SOURCES - 1){1'b1}}, 1'b0};
   int wdCount; // Cycles since the last watchdog tick.
   int oscCount; // Counted source cycles since the last source tick.
   logic half; // Toggles each cycle; a stalled oscillator only advances on one half.
   logic step; // High when the source counter may advance this cycle.
   assign step = !stall || half;
   // Restarting the phase on release makes start-up lengths repeatable to one cycle.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst || phaseReset) begin
         wdCount <= 0;
         oscCount <= 0;
         half <= 1'b0;
         watchdogTick <= 1'b0;
         oscillatorTick <= '0;
      end else begin
         half <= ~half;
         wdCount <= (wdCount == WD_PERIOD - 1) ? 0 : wdCount + 1;
         watchdogTick <= (wdCount == WD_PERIOD - 1);
         if (step) begin
            oscCount <= (oscCount == OSC_PERIOD - 1) ? 0 : oscCount + 1;
         end
         oscillatorTick <= (step && oscCount == OSC_PERIOD - 1) ? ALL_TICKS : '0;
      end
   end
endmodule

// file: bench/css_clock_source_startup_sequencer_tb.sv
// Self-checking bench for the start-up sequencer: fuse decode, reset timing, sleep and APB.
// Assumes the oscillator partner model ticks every 7 cycles and the watchdog every 2.
`timescale 1ns/1ps
module css_clock_source_startup_sequencer_tb;
   import css_pkg::*;
   localparam int OSC_P = 7; // Source tick period in clk cycles.
   localparam int WD_P = 2; // Watchdog tick period in clk cycles.
   localparam int T_LONG = 20; // Shortened long time-out.
   logic clk, nrst, divideByEightFuse, otherResetActive, wakeUp, stall;
   logic [3:0] clockSourceSelect;
   logic [1:0] startupTimeSelect;
   logic watchdogTick;
   logic [CSS_NUM_SOURCES-1:0] oscillatorTick;
   logic coreReset, systemClockEnable, cpuClockEnable, ioClockEnable, converterClockEnable;
   logic [2:0] oscillatorRangeSelect;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   int failCount = 0;
   int totalChecks = 0;
   int cycles = 0;
   logic [33:0] expQ[$]; // Bit 33 marks a read, bit 32 the expected error, low word the data.

   css_clock_source_startup_sequencer #(.TIMEOUT_LONG_CYCLES(T_LONG), .START_16K_CYCLES(30),
      .START_32K_CYCLES(40)) css_clock_source_startup_sequencer_i (.clk(clk), .nrst(nrst),
      .clockSourceSelect(clockSourceSelect), .startupTimeSelect(startupTimeSelect),
      .divideByEightFuse(divideByEightFuse), .otherResetActive(otherResetActive),
      .watchdogTick(watchdogTick), .oscillatorTick(oscillatorTick), .wakeUp(wakeUp),
      .coreReset(coreReset), .systemClockEnable(systemClockEnable), .cpuClockEnable(cpuClockEnable),
      .ioClockEnable(ioClockEnable), .converterClockEnable(converterClockEnable),
      .oscillatorRangeSelect(oscillatorRangeSelect), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // The model restarts its phases on release and on wake so cycle counts are predictable.
   css_osc_model css_osc_model_i (.clk(clk), .nrst(nrst), .phaseReset(otherResetActive | wakeUp),
      .stall(stall), .watchdogTick(watchdogTick), .oscillatorTick(oscillatorTick));

   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Prints the verdict and ends the run.
   task automatic results();
      if (failCount == 0 && totalChecks > 0 && expQ.size() == 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Compares one word.
   task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         failCount++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask

   // Compares a measured count against a window.
   task automatic checkRange(input int got, input int lo, input int hi);
      totalChecks++;
      if (got < lo || got > hi) begin
         failCount++;
         $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask

   // One APB transfer; the expectation goes on the queue for the monitor.
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
      input logic [31:0] expData, input logic expErr);
      int n;
      n = 0;
      expQ.push_back({!wr, expErr, expData});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Takes the oldest expectation whenever the slave answers.
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         if (expQ.size() == 0) begin
            failCount++;
            $display("ERROR %0t answer with nothing requested", $time);
         end else begin
            checkVal({31'h0, pslverr}, {31'h0, expQ[0][32]});
            if (expQ[0][33]) begin
               checkVal(prdata, expQ[0][31:0]);
            end
            void'(expQ.pop_front());
         end
      end
   end

   // Waits for the core to run; exp below zero only asks that it runs at all.
   task automatic waitRun(input int exp);
      int n;
      n = 0;
      while (!(coreReset === 1'b0 && cpuClockEnable === 1'b1) && n < 9000) begin
         @(posedge clk);
         n++;
      end
      if (exp >= 0) begin
         checkRange(n, exp - 2, exp + 5);
      end else begin
         checkRange(n, 0, 8999);
      end
   endtask

   // Sets fuses under another reset, releases it and, unless exp is -2, waits for the run.
   task automatic boot(input logic [3:0] src, input logic [1:0] sut, input logic div, input int exp);
      otherResetActive <= 1'b1;
      clockSourceSelect <= src;
      startupTimeSelect <= sut;
      divideByEightFuse <= div;
      repeat (3) @(posedge clk);
      otherResetActive <= 1'b0;
      @(posedge clk);
      if (exp != -2) begin
         waitRun(exp);
      end
   endtask

   // Counts system clock pulses over 80 source ticks.
   task automatic countSys(input int lo, input int hi);
      int n;
      n = 0;
      repeat (80 * OSC_P) begin
         @(posedge clk);
         if (systemClockEnable === 1'b1) n++;
      end
      checkRange(n, lo, hi);
   endtask

   // A hang is cut short well above the expected run length.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 95000) begin
         failCount++;
         $display("ERROR %0t run did not finish", $time);
         results();
      end
   end

   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      otherResetActive = 1'b1;
      clockSourceSelect = CSS_DEFAULT_SOURCE;
      startupTimeSelect = CSS_DEFAULT_STARTUP;
      divideByEightFuse = CSS_DEFAULT_DIV;
      wakeUp = 1'b0;
      stall = 1'b0;
      void'($urandom(32'hCA77DC7F));
      repeat (20) @(posedge clk);
      checkVal({28'h0, coreReset, cpuClockEnable, ioClockEnable, converterClockEnable}, 32'h8);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, CSS_ADDR_FUSES, 32'h0, 32'h22, 1'b0);
      apb(1'b1, CSS_ADDR_FUSES, 32'h0, 32'h0, 1'b1);
      apb(1'b0, 8'(4 * $urandom_range(62, 3)), 32'h0, 32'h0, 1'b1);
      // Shipped fuses: long time-out, then start-up count plus the reset extra, then divided clock.
      // The start-up count waits on source ticks whose phase runs on through the time-out.
      boot(CSS_DEFAULT_SOURCE, CSS_DEFAULT_STARTUP, CSS_DEFAULT_DIV,
         OSC_P * (T_LONG * WD_P / OSC_P + 20));
      countSys(9, 11);
      apb(1'b0, CSS_ADDR_STATUS, 32'h0, 32'h23, 1'b0);
      boot(4'h2, 2'h1, 1'b1, OSC_P * (CSS_TIMEOUT_SHORT * WD_P / OSC_P + 20));
      // A second reset in mid time-out must restart both counts from zero.
      boot(4'h2, 2'h1, 1'b1, -2);
      repeat (300) @(posedge clk);
      checkVal({31'h0, coreReset}, 32'h1);
      boot(4'h2, 2'h1, 1'b1, OSC_P * (CSS_TIMEOUT_SHORT * WD_P / OSC_P + 20));
      boot(4'h0, 2'h0, 1'b1, 20 * OSC_P);
      countSys(79, 81);
      // Power-down wake uses the start-up count alone.
      apb(1'b1, CSS_ADDR_CONTROL, {30'h0, CSS_MODE_POWERDOWN}, 32'h0, 1'b0);
      repeat (2) @(posedge clk);
      checkVal({29'h0, coreReset, cpuClockEnable, converterClockEnable}, 32'h0);
      wakeUp <= 1'b1;
      @(posedge clk);
      wakeUp <= 1'b0;
      waitRun(6 * OSC_P);
      apb(1'b0, CSS_ADDR_CONTROL, 32'h0, 32'h0, 1'b0);
      // Noise reduction halts CPU and I/O but keeps the converter clock.
      apb(1'b1, CSS_ADDR_CONTROL, {30'h0, CSS_MODE_NOISE}, 32'h0, 1'b0);
      repeat (2) @(posedge clk);
      checkVal({29'h0, cpuClockEnable, ioClockEnable, converterClockEnable}, 32'h1);
      wakeUp <= 1'b1;
      @(posedge clk);
      wakeUp <= 1'b0;
      waitRun(0);
      // Every source code; a slow oscillator only on the short ones to bound the run.
      for (int c = 0; c < 16; c++) begin
         stall <= (c < 4) ? 1'($urandom_range(1, 0)) : 1'b0;
         boot(4'(c), 2'h0, 1'b1, (c == 1) ? -2 : -1);
         if (c == 1) repeat (2000) @(posedge clk);
         checkVal({29'h0, oscillatorRangeSelect}, (c >= 8) ? 32'(c >> 1) : 32'h0);
         apb(1'b0, CSS_ADDR_STATUS, 32'h0, (c == 1) ? 32'h11A : 32'(c * 16 + 3), 1'b0);
      end
      results();
   end
endmodule
